// [dv/retimer_lowpower_loopback_fsm_tb_top.sv]
// testbench: low-power exits, recovery and loopback of the link-state control
`timescale 1ns/1ps
`default_nettype none
module retimer_lowpower_loopback_fsm_tb_top;
  import rlf_pkg::*;
  localparam int RESP = 60;
  localparam int WARM = 100;
  localparam int RELAY = 10;
  localparam int LBEX = 40;
  typedef struct packed { logic [7:0] cfg; rlf_state_e st; } rlf_row_s;
  logic       clk, rst, enter_u2, enter_u3, recovery_done, rec_idle_done, lfps_handshake_ok, gen1_rate;
  logic       lfps_tx_ready, hs_ready, lb_exit_lfps, answer, err_corr_en, skp_consume_en, hs_pwr_en, warm_reset_det;
  logic       lb_exit_hs;
  logic [1:0] lfps_det, lfps_is_ping, far_end_open, rx_trained, ts2_seen, lfps_tx_en, lfps_pwr_en;
  logic [1:0] lfps_rx_status, rx_term_en, ts2_fwd_en, loop_port;
  logic [7:0] ts2_link_cfg, dly;
  rlf_state_e state;
  rlf_tx_e    tx_mode_0, tx_mode_1;
  int         n_mismatch, tests_run;
  rlf_row_s   rows [4] = '{'{8'h00, RLF_U0}, '{8'h10, RLF_LLB_ACTIVE}, '{8'h14, RLF_PT_LB}, '{8'h04, RLF_PT_LB}};
  rlf_link_fsm #(.LFPS_RESP_CYCLES(RESP), .WARM_RESET_CYCLES(WARM), .U3_RELAY_CYCLES(RELAY),
    .HS_READY_CYCLES(200), .LB_EXIT_CYCLES(LBEX)) dut (.clk, .rst, .enter_u2, .enter_u3, .recovery_done,
    .rec_idle_done, .lfps_det, .lfps_is_ping, .lfps_handshake_ok, .far_end_open, .rx_trained, .ts2_seen,
    .ts2_link_cfg, .gen1_rate, .lfps_tx_ready, .hs_ready, .lb_exit_lfps, .lb_exit_handshake_ok(lb_exit_hs), .state,
    .tx_mode_0, .tx_mode_1, .lfps_tx_en, .lfps_pwr_en, .lfps_rx_status, .rx_term_en, .ts2_fwd_en, .err_corr_en,
    .skp_consume_en, .hs_pwr_en, .loop_port, .warm_reset_det);
  rlf_link_partner partner (.clk, .rst, .answer, .dly, .lfps_tx_en, .lfps_handshake_ok);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_st(input rlf_state_e s, input int lim);
    for (int i = 0; i < lim && state !== s; i++) step(1);
    check("state", 8'(state), 8'(s));
  endtask
  task automatic rst_dut();
    rst = 1'b1;
    {enter_u2, enter_u3, recovery_done, rec_idle_done, hs_ready, lb_exit_lfps, lb_exit_hs} = '0;
    {lfps_det, lfps_is_ping, far_end_open, rx_trained, ts2_seen} = '0;
    ts2_link_cfg = 8'h00;
    dly = 8'd8;
    answer = 1'b1;
    step(8);
    check("reset state", 8'(state), 8'(RLF_RX_DETECT));
    check("reset term", {6'h0, rx_term_en}, 8'h03);
    rst = 1'b0;
    step(2);
  endtask
  // reset, come up to u0, then drop into u2 or u3
  task automatic to_state(input logic u3);
    rst_dut();
    recovery_done = 1'b1;
    step(1);
    recovery_done = 1'b0;
    wait_st(RLF_U0, 5);
    enter_u2 = !u3;
    enter_u3 = u3;
    step(1);
    {enter_u2, enter_u3} = 2'h0;
    wait_st(u3 ? RLF_U3 : RLF_U2, 5);
  endtask
  task automatic burst(input int p, input int len);
    lfps_det[p] = 1'b1;
    step(len);
    lfps_det[p] = 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    gen1_rate = 1'b1;
    lfps_tx_ready = 1'b0;
    rst_dut();
    foreach (rows[i]) begin
      to_state(1'b0);
      burst(0, 20);
      wait_st(RLF_REC_TSX, 60);
      check("local ts1", 8'(tx_mode_0), 8'(RLF_TX_TS1_LOC));
      rx_trained = 2'h1;
      step(3);
      check("ts2 held", {6'h0, ts2_fwd_en}, 8'h00);
      rx_trained = 2'h3;
      step(2);
      check("forward", 8'(tx_mode_1), 8'(RLF_TX_FWD));
      ts2_seen = 2'h3;
      wait_st(RLF_REC_IDLE, 10);
      ts2_link_cfg = rows[i].cfg;
      rec_idle_done = 1'b1;
      wait_st(rows[i].st, 10);
      rec_idle_done = 1'b0;
      if (rows[i].st == RLF_LLB_ACTIVE) begin
        // loop_port trails the state output by one register stage
        step(1);
        check("loop port", {6'h0, loop_port}, 8'h01);
        lb_exit_lfps = 1'b1;
        wait_st(RLF_LLB_EXIT, 6);
        lb_exit_hs = 1'b1;
        wait_st(RLF_RX_DETECT, 6);
        {lb_exit_lfps, lb_exit_hs} = 2'h0;
      end
    end
    $display("test rows finished");
    check("no ecc", {7'h0, err_corr_en}, 8'h00);
    check("skip use", {7'h0, skp_consume_en}, 8'h01);
    lb_exit_lfps = 1'b1;
    step(20);
    check("exit timer runs", 8'(state), 8'(RLF_PT_LB));
    wait_st(RLF_RX_DETECT, LBEX);
    lb_exit_lfps = 1'b0;
    $display("test loopback exit finished");
    to_state(1'b0);
    answer = 1'b0;
    burst(0, 20);
    check("no answer yet", 8'(state), 8'(RLF_U2));
    wait_st(RLF_RX_DETECT, RESP);
    $display("test u2 timeout finished");
    to_state(1'b0);
    lfps_is_ping = 2'h3;
    burst(0, 20);
    check("ping ignored", 8'(state), 8'(RLF_U2));
    check("ping not relayed", {6'h0, lfps_tx_en}, 8'h00);
    lfps_is_ping = 2'h0;
    far_end_open = 2'h1;
    wait_st(RLF_RX_DETECT, 6);
    check("term mirror", {6'h0, rx_term_en}, 8'h02);
    far_end_open = 2'h0;
    $display("test ping and far end finished");
    to_state(1'b1);
    dly = 8'd30;
    lfps_det[1] = 1'b1;
    step(RELAY + 6);
    check("u3 relay", {6'h0, lfps_tx_en}, 8'h01);
    step(40);
    check("u3 waits hs", 8'(state), 8'(RLF_U3));
    check("lfps kept", {6'h0, lfps_tx_en}, 8'h01);
    hs_ready = 1'b1;
    wait_st(RLF_REC_TSX, 10);
    lfps_det[1] = 1'b0;
    $display("test u3 wake finished");
    to_state(1'b0);
    burst(1, WARM + 20);
    check("warm seen", {7'h0, warm_reset_det}, 8'h01);
    wait_st(RLF_RX_DETECT, 5);
    $display("test warm reset finished");
    end_of_test();
  end
  initial begin
    #(50 * 8000);
    n_mismatch++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule // retimer_lowpower_loopback_fsm_tb_top
`default_nettype wire

// [dv/rlf_link_fsm_monitor.sv]
// checker: link-state timing and ordering relations at the fsm ports
`timescale 1ns/1ps
`default_nettype none
module rlf_link_fsm_monitor
  import rlf_pkg::*;
#(
  parameter int unsigned LFPS_RESP_CYCLES = 50,
  parameter int unsigned U3_RELAY_CYCLES  = 10
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       hs_ready,
  input wire logic [1:0] far_end_open,
  input wire logic [1:0] rx_trained,
  input wire logic [7:0] ts2_link_cfg,
  input wire logic       gen1_rate,
  input wire rlf_state_e state,
  input wire logic [1:0] lfps_tx_en,
  input wire logic [1:0] lfps_rx_status,
  input wire logic [1:0] ts2_fwd_en,
  input wire logic       err_corr_en,
  input wire logic       skp_consume_en,
  input wire logic       warm_reset_det
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [23:0] u2_wait_reg;
  logic [23:0] u3_wait_reg;
  // counters, not repetitions: the timeouts are far beyond what a repetition may unroll
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      u2_wait_reg <= '0;
    else
      u2_wait_reg <= (state == RLF_U2 && lfps_tx_en != 2'h0) ? u2_wait_reg + 24'h1 : '0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      u3_wait_reg <= '0;
    else
      u3_wait_reg <= (state == RLF_U3 && lfps_rx_status != 2'h0 && lfps_tx_en == 2'h0) ? u3_wait_reg + 24'h1 : '0;
  end
  u2_resp_timer_a: assert property (u2_wait_reg <= LFPS_RESP_CYCLES + 4)
    else $error("u2 wake outlived the response timer");
  u3_relay_time_a: assert property (u3_wait_reg <= U3_RELAY_CYCLES + 3)
    else $error("u3 wake relay started late");
  u3_hs_gate_a: assert property (state == RLF_U3 && !hs_ready |=> state != RLF_REC_TSX)
    else $error("u3 left for recovery without high-speed readiness");
  far_open_exit_a: assert property ((state inside {RLF_U2, RLF_U3}) && far_end_open != 2'h0 |-> ##[0:4] state == RLF_RX_DETECT)
    else $error("far-end open did not reach rx detect");
  warm_to_detect_a: assert property ($rose(warm_reset_det) |-> ##[0:2] state == RLF_RX_DETECT)
    else $error("warm reset did not reach rx detect");
  ts2_hold_a: assert property (state == RLF_REC_TSX && rx_trained != 2'h3 |=> ts2_fwd_en == 2'h0)
    else $error("ts2 forwarded before both receivers trained");
  lb_priority_a: assert property (state == RLF_REC_IDLE && ts2_link_cfg[2] |=> state != RLF_LLB_ACTIVE)
    else $error("local loopback chosen over passthrough");
  no_err_corr_a: assert property (state == RLF_PT_LB [*2] |-> !err_corr_en)
    else $error("error correction on in passthrough loopback");
  gen1_skp_a: assert property ((state == RLF_PT_LB && gen1_rate) [*2] |-> skp_consume_en)
    else $error("skip sets not consumed in passthrough loopback");
  cover property (state == RLF_U3 ##1 state == RLF_REC_TSX);
  cover property (state == RLF_PT_LB ##1 state == RLF_RX_DETECT);
  cover property (state == RLF_LLB_ACTIVE);
endmodule // rlf_link_fsm_monitor
bind rlf_link_fsm rlf_link_fsm_monitor #(.LFPS_RESP_CYCLES(LFPS_RESP_CYCLES), .U3_RELAY_CYCLES(U3_RELAY_CYCLES))
  u_mon (.clk, .rst, .hs_ready, .far_end_open, .rx_trained, .ts2_link_cfg, .gen1_rate, .state, .lfps_tx_en,
  .lfps_rx_status, .ts2_fwd_en, .err_corr_en, .skp_consume_en, .warm_reset_det);
`default_nettype wire

// [dv/rlf_link_partner.sv]
// partner: far link port that answers the relayed wake burst
`timescale 1ns/1ps
`default_nettype none
module rlf_link_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       answer,
  input  wire logic [7:0] dly,
  input  wire logic [1:0] lfps_tx_en,
  output logic            lfps_handshake_ok
);
  int unsigned seen;
  // success only while our burst is still heard; it drops as soon as the burst stops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen <= 0;
      lfps_handshake_ok <= 1'b0;
    end else begin
      seen <= (lfps_tx_en != 2'h0) ? seen + 1 : 0;
      lfps_handshake_ok <= answer && lfps_tx_en != 2'h0 && seen >= dly;
    end
  end
endmodule // rlf_link_partner
`default_nettype wire

// [rtl/rlf_link_fsm.sv]
// link-state control for the two-port retimer: u2/u3 exit, recovery, loopback
// Notes on behaviour
// - u2 non-ping lfps: answer, forward, time burst
// - classify bursts as ping or wake exit
// - u2 to recovery after good wake handshake
// - u2/u3 warm reset or far-end open: rx.detect
// - u2 handshake timer expiry goes rx.detect
// - warm reset still forces rx.detect after wake
// - u3 wake relayed within 100 us
// - relay u3 wake only after detecting it
// - no command wait; power transmitter, then send
// - high-speed ready within 2 ms of u3 wake
// - keep lfps until high-speed ready
// - u3 to recovery needs handshake and readiness
// - recovery entry sends local ts1 both ways
// - both trained: forward received ts1/ts2
// - hold ts2 until other receiver trained
// - recovery has only tsx and idle substates
// - passthrough loopback forwards, no error correction
// - gen1 passthrough loopback consumes skip sets
// - loopback exit timer, exit to rx.detect
// - local loopback: slave port loops, other rx.detect
// - active: warm reset only from rx.detect port
// - exit lfps to exit; handshake/warm reset ends
// - ts2 bit 2 passthrough, bit 4 local, 2 wins
`timescale 1ns/1ps
`default_nettype none
module rlf_link_fsm
  import rlf_pkg::*;
#(
  parameter int unsigned LFPS_RESP_CYCLES = rlf_pkg::LFPS_RESP_CYC,
  parameter int unsigned WARM_RESET_CYCLES = rlf_pkg::WARM_RESET_CYC,
  parameter int unsigned U3_RELAY_CYCLES  = rlf_pkg::U3_RELAY_CYC,
  parameter int unsigned HS_READY_CYCLES  = rlf_pkg::HS_READY_CYC,
  parameter int unsigned LB_EXIT_CYCLES   = rlf_pkg::LB_EXIT_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                enter_u2,
  input  wire logic                enter_u3,
  input  wire logic                recovery_done,
  input  wire logic                rec_idle_done,
  input  wire logic [1:0]          lfps_det,
  input  wire logic [1:0]          lfps_is_ping,
  input  wire logic                lfps_handshake_ok,
  input  wire logic [1:0]          far_end_open,
  input  wire logic [1:0]          rx_trained,
  input  wire logic [1:0]          ts2_seen,
  input  wire logic [7:0]          ts2_link_cfg,
  input  wire logic                gen1_rate,
  input  wire logic                lfps_tx_ready,
  input  wire logic                hs_ready,
  input  wire logic                lb_exit_lfps,
  input  wire logic                lb_exit_handshake_ok,
  output rlf_pkg::rlf_state_e      state,
  output rlf_pkg::rlf_tx_e         tx_mode_0,
  output rlf_pkg::rlf_tx_e         tx_mode_1,
  output logic [1:0]               lfps_tx_en,
  output logic [1:0]               lfps_pwr_en,
  output logic [1:0]               lfps_rx_status,
  output logic [1:0]               rx_term_en,
  output logic [1:0]               ts2_fwd_en,
  output logic                     err_corr_en,
  output logic                     skp_consume_en,
  output logic                     hs_pwr_en,
  output logic [1:0]               loop_port,
  output logic                     warm_reset_det
);
  // async pins sampled through two flops each
  logic [1:0] det_s1_reg, det_s2_reg;
  logic [1:0] ping_s1_reg, ping_s2_reg;
  logic [1:0] open_s1_reg, open_s2_reg;
  logic [2:0] evt_s1_reg, evt_s2_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_s1_reg  <= 2'h0;
      det_s2_reg  <= 2'h0;
      ping_s1_reg <= 2'h0;
      ping_s2_reg <= 2'h0;
      open_s1_reg <= 2'h0;
      open_s2_reg <= 2'h0;
      evt_s1_reg  <= 3'h0;
      evt_s2_reg  <= 3'h0;
    end else begin
      det_s1_reg  <= lfps_det;
      det_s2_reg  <= det_s1_reg;
      ping_s1_reg <= lfps_is_ping;
      ping_s2_reg <= ping_s1_reg;
      open_s1_reg <= far_end_open;
      open_s2_reg <= open_s1_reg;
      evt_s1_reg  <= {lfps_handshake_ok, lb_exit_lfps, lb_exit_handshake_ok};
      evt_s2_reg  <= evt_s1_reg;
    end
  end

  logic       hs_ok_s, lbx_lfps_s, lbx_hs_s;
  logic [1:0] wake;
  logic [1:0] det_prev_reg;
  logic [1:0] wake_rise;
  assign hs_ok_s    = evt_s2_reg[2];
  assign lbx_lfps_s = evt_s2_reg[1];
  assign lbx_hs_s   = evt_s2_reg[0];
  assign wake       = det_s2_reg & ~ping_s2_reg;
  assign wake_rise  = wake & ~det_prev_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_prev_reg <= 2'h0;
    end else begin
      det_prev_reg <= wake;
    end
  end

  // burst length per port; long non-ping burst is warm reset
  logic [TMR_W-1:0] burst_cnt_reg [2];
  logic [1:0]       wr_port;
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_burst
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          burst_cnt_reg[gp] <= '0;
        end else if (!wake[gp]) begin
          burst_cnt_reg[gp] <= '0;
        end else if (burst_cnt_reg[gp] < TMR_W'(WARM_RESET_CYCLES)) begin
          burst_cnt_reg[gp] <= burst_cnt_reg[gp] + TMR_W'(1);
        end
      end
      assign wr_port[gp] = burst_cnt_reg[gp] >= TMR_W'(WARM_RESET_CYCLES);
    end
  endgenerate

  rlf_state_e state_reg, state_next;
  logic [1:0] loop_port_reg;
  logic       warm_any;
  // looping port sees warm reset as exit lfps, only the other port counts
  assign warm_any = (state_reg == RLF_LLB_ACTIVE) ? |(wr_port & ~loop_port_reg) : |wr_port;

  // timers
  logic resp_run, resp_exp, lbx_run, lbx_exp, hs_run, hs_exp;
  logic in_u2, in_u3;
  assign in_u2 = state_reg == RLF_U2;
  assign in_u3 = state_reg == RLF_U3;

  rlf_timer #(.W(TMR_W)) u_resp_tmr (
    .clk     (clk),
    .rst     (rst),
    .start   (in_u2 && |wake_rise && !resp_run),
    .stop    (!in_u2),
    .load    (TMR_W'(LFPS_RESP_CYCLES)),
    .running (resp_run),
    .expired (resp_exp)
  );

  rlf_timer #(.W(TMR_W)) u_lbx_tmr (
    .clk     (clk),
    .rst     (rst),
    .start   (state_reg == RLF_PT_LB && lbx_lfps_s && !lbx_run),
    .stop    (state_reg != RLF_PT_LB),
    .load    (TMR_W'(LB_EXIT_CYCLES)),
    .running (lbx_run),
    .expired (lbx_exp)
  );

  rlf_timer #(.W(TMR_W)) u_hs_tmr (
    .clk     (clk),
    .rst     (rst),
    .start   (in_u3 && |wake_rise && !hs_run),
    .stop    (!in_u3 || hs_ready),
    .load    (TMR_W'(HS_READY_CYCLES)),
    .running (hs_run),
    .expired (hs_exp)
  );

  // u3 wake seen and not yet resolved
  logic       u3_wake_reg;
  logic [1:0] u3_src_reg;
  logic [TMR_W-1:0] relay_cnt_reg;
  logic       u3_hs_done_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      u3_wake_reg    <= 1'b0;
      u3_src_reg     <= 2'h0;
      relay_cnt_reg  <= '0;
      u3_hs_done_reg <= 1'b0;
    end else if (!in_u3) begin
      u3_wake_reg    <= 1'b0;
      u3_src_reg     <= 2'h0;
      relay_cnt_reg  <= '0;
      u3_hs_done_reg <= 1'b0;
    end else if (!u3_wake_reg) begin
      if (|wake_rise) begin
        u3_wake_reg <= 1'b1;
        u3_src_reg  <= wake_rise[0] ? 2'h1 : 2'h2;
      end
    end else begin
      if (relay_cnt_reg < TMR_W'(U3_RELAY_CYCLES)) begin
        relay_cnt_reg <= relay_cnt_reg + TMR_W'(1);
      end
      if (hs_ok_s) begin
        u3_hs_done_reg <= 1'b1;
      end
      // failed handshake: drop back to plain u3 and wait for a new wake
      if (!(|wake) && !hs_ok_s && !u3_hs_done_reg && !(|lfps_tx_en)) begin
        u3_wake_reg <= 1'b0;
      end
    end
  end

  // late start would break the relay deadline, so start forced at the limit
  logic relay_go;
  assign relay_go = u3_wake_reg && (lfps_tx_ready || relay_cnt_reg >= TMR_W'(U3_RELAY_CYCLES));

  // loopback selection from ts2 link config
  logic sel_pt, sel_llb;
  assign sel_pt  = ts2_link_cfg[LCFG_PASSTHRU_BIT];
  assign sel_llb = ts2_link_cfg[LCFG_LOCAL_LB_BIT] && !sel_pt;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RLF_RX_DETECT: begin
        if (recovery_done) begin
          state_next = RLF_U0;
        end
      end
      RLF_U0: begin
        if (warm_any) begin
          state_next = RLF_RX_DETECT;
        end else if (enter_u2) begin
          state_next = RLF_U2;
        end else if (enter_u3) begin
          state_next = RLF_U3;
        end
      end
      RLF_U2: begin
        if (warm_any || |open_s2_reg || resp_exp) begin
          state_next = RLF_RX_DETECT;
        end else if (hs_ok_s && resp_run) begin
          state_next = RLF_REC_TSX;
        end
      end
      RLF_U3: begin
        if (warm_any || |open_s2_reg) begin
          state_next = RLF_RX_DETECT;
        end else if (u3_hs_done_reg && hs_ready) begin
          state_next = RLF_REC_TSX;
        end
      end
      RLF_REC_TSX: begin
        if (warm_any) begin
          state_next = RLF_RX_DETECT;
        end else if (&ts2_seen && &rx_trained) begin
          state_next = RLF_REC_IDLE;
        end
      end
      RLF_REC_IDLE: begin
        if (warm_any) begin
          state_next = RLF_RX_DETECT;
        end else if (sel_pt) begin
          state_next = RLF_PT_LB;
        end else if (sel_llb) begin
          state_next = RLF_LLB_ACTIVE;
        end else if (rec_idle_done) begin
          state_next = RLF_U0;
        end
      end
      RLF_PT_LB: begin
        if (warm_any || lbx_exp || (lbx_run && lbx_hs_s)) begin
          state_next = RLF_RX_DETECT;
        end
      end
      RLF_LLB_ACTIVE: begin
        if (warm_any) begin
          state_next = RLF_RX_DETECT;
        end else if (lbx_lfps_s) begin
          state_next = RLF_LLB_EXIT;
        end
      end
      RLF_LLB_EXIT: begin
        if (|wr_port || lbx_hs_s) begin
          state_next = RLF_RX_DETECT;
        end
      end
      default: begin
        state_next = RLF_RX_DETECT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= RLF_RX_DETECT;
    end else begin
      state_reg <= state_next;
    end
  end

  // port that saw the loopback ts2 loops, the other sits in rx.detect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_port_reg <= 2'h0;
    end else if (state_reg == RLF_REC_IDLE && state_next == RLF_LLB_ACTIVE) begin
      loop_port_reg <= ts2_seen[0] ? 2'h1 : 2'h2;
    end else if (state_next != RLF_LLB_ACTIVE && state_next != RLF_LLB_EXIT) begin
      loop_port_reg <= 2'h0;
    end
  end

  // registered outputs
  logic rec_next, both_trained;
  assign rec_next     = state_next == RLF_REC_TSX || state_next == RLF_REC_IDLE;
  assign both_trained = &rx_trained;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state          <= RLF_RX_DETECT;
      tx_mode_0      <= RLF_TX_IDLE;
      tx_mode_1      <= RLF_TX_IDLE;
      lfps_tx_en     <= 2'h0;
      lfps_pwr_en    <= 2'h0;
      lfps_rx_status <= 2'h0;
      rx_term_en     <= 2'h3;
      ts2_fwd_en     <= 2'h0;
      err_corr_en    <= 1'b0;
      skp_consume_en <= 1'b0;
      hs_pwr_en      <= 1'b0;
      loop_port      <= 2'h0;
      warm_reset_det <= 1'b0;
    end else begin
      state          <= state_next;
      loop_port      <= loop_port_reg;
      warm_reset_det <= warm_any;
      lfps_rx_status <= det_s2_reg;
      // mirror a far-end open on our own receiver termination
      rx_term_en     <= (in_u2 || in_u3) ? ~open_s2_reg : 2'h3;
      // u2: handshake answer on the source port plus forward on the other
      if (in_u2) begin
        lfps_tx_en  <= {2{|wake}};
        lfps_pwr_en <= {2{|wake}};
      end else if (in_u3) begin
        lfps_pwr_en <= u3_wake_reg ? ~u3_src_reg : 2'h0;
        if (relay_go && (|wake || !hs_ready || !u3_hs_done_reg)) begin
          lfps_tx_en <= ~u3_src_reg;
        end else begin
          lfps_tx_en <= 2'h0;
        end
      end else begin
        lfps_tx_en  <= 2'h0;
        lfps_pwr_en <= 2'h0;
      end
      hs_pwr_en   <= !(state_next == RLF_U2 || state_next == RLF_U3) || u3_wake_reg || hs_run;
      err_corr_en <= state_next == RLF_U0;
      skp_consume_en <= state_next == RLF_PT_LB && gen1_rate;
      ts2_fwd_en  <= (rec_next && both_trained) ? 2'h3 : 2'h0;
      if (rec_next) begin
        tx_mode_0 <= both_trained ? RLF_TX_FWD : RLF_TX_TS1_LOC;
        tx_mode_1 <= both_trained ? RLF_TX_FWD : RLF_TX_TS1_LOC;
      end else if (state_next == RLF_LLB_ACTIVE || state_next == RLF_LLB_EXIT) begin
        tx_mode_0 <= loop_port_reg[0] || state_reg == RLF_REC_IDLE && ts2_seen[0] ? RLF_TX_FWD : RLF_TX_IDLE;
        tx_mode_1 <= loop_port_reg[1] || state_reg == RLF_REC_IDLE && !ts2_seen[0] ? RLF_TX_FWD : RLF_TX_IDLE;
      end else if (state_next == RLF_U0 || state_next == RLF_PT_LB) begin
        tx_mode_0 <= RLF_TX_FWD;
        tx_mode_1 <= RLF_TX_FWD;
      end else if (|lfps_tx_en) begin
        tx_mode_0 <= lfps_tx_en[0] ? RLF_TX_LFPS : RLF_TX_IDLE;
        tx_mode_1 <= lfps_tx_en[1] ? RLF_TX_LFPS : RLF_TX_IDLE;
      end else begin
        tx_mode_0 <= RLF_TX_IDLE;
        tx_mode_1 <= RLF_TX_IDLE;
      end
    end
  end
endmodule // rlf_link_fsm
`default_nettype wire

// [rtl/rlf_pkg.sv]
// package: constants and state types for the retimer low-power / loopback link-state control
`default_nettype none
package rlf_pkg;
  localparam int unsigned CLK_HZ               = 20_000_000;
  localparam int unsigned LFPS_RESP_TIME_US    = 2000;  // lfps_response_timer, 2 ms
  localparam int unsigned LFPS_RESP_CYC        = LFPS_RESP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WARM_RESET_TIME_US   = 2000;  // burst longer than this is warm reset
  localparam int unsigned WARM_RESET_CYC       = WARM_RESET_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned U3_RELAY_TIME_US     = 100;   // latest start of u3 wake relay
  localparam int unsigned U3_RELAY_CYC         = U3_RELAY_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HS_READY_TIME_US     = 2000;  // high-speed readiness deadline
  localparam int unsigned HS_READY_CYC         = HS_READY_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LB_EXIT_TIME_US      = 2000;  // loopback_exit_timer default
  localparam int unsigned LB_EXIT_CYC          = LB_EXIT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LCFG_PASSTHRU_BIT    = 2;
  localparam int unsigned LCFG_LOCAL_LB_BIT    = 4;
  localparam int unsigned TMR_W                = 24;

  typedef enum logic [3:0] {
    RLF_RX_DETECT  = 4'h0,
    RLF_U0         = 4'h1,
    RLF_U2         = 4'h3,
    RLF_U3         = 4'h2,
    RLF_REC_TSX    = 4'h6,
    RLF_REC_IDLE   = 4'h7,
    RLF_PT_LB      = 4'h5,
    RLF_LLB_ACTIVE = 4'h4,
    RLF_LLB_EXIT   = 4'hc
  } rlf_state_e;

  typedef enum logic [1:0] {
    RLF_TX_IDLE    = 2'h0,
    RLF_TX_LFPS    = 2'h1,
    RLF_TX_TS1_LOC = 2'h3,
    RLF_TX_FWD     = 2'h2
  } rlf_tx_e;
endpackage : rlf_pkg
`default_nettype wire

// [rtl/rlf_timer.sv]
// down counter used for the u2 response, loopback exit and high-speed readiness timeouts
`timescale 1ns/1ps
`default_nettype none
module rlf_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] load,
  output logic              running,
  output logic              expired
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (stop) begin
      running <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      cnt_reg <= load;
      running <= 1'b1;
      expired <= 1'b0;
    end else if (running) begin
      if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
        running <= 1'b0;
        expired <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
    end else begin
      expired <= 1'b0;
    end
  end
endmodule // rlf_timer
`default_nettype wire
